/* File: hw/ilsu_pkg.sv */
package ilsu_pkg;

    // Operand sizes
    typedef enum logic [1:0] {
        ILSU_SZ_BYTE = 2'b00,
        ILSU_SZ_HALF = 2'b01,
        ILSU_SZ_WORD = 2'b10
    } ilsu_size_t;

    // Widths
    localparam int unsigned ILSU_DATA_W = 32;
    localparam int unsigned ILSU_REG_W = 5;
    localparam int unsigned ILSU_DISP_W = 16;
    localparam int unsigned ILSU_NREGS = 32;

    // Register reset value and the register number read as a zero base
    localparam logic [31:0] ILSU_GPR_RST = 32'h0000_0000;
    localparam logic [4:0] ILSU_ZERO_REG = 5'h00;

    // Byte-lane strobes, lane 0 carries the most significant byte
    localparam logic [3:0] ILSU_BE_NONE = 4'h0;
    localparam logic [3:0] ILSU_BE_ALL = 4'hf;

    // One load/store request from the issue side
    typedef struct packed {
        logic is_store;
        logic indexed;
        logic update;
        logic algebraic;
        ilsu_size_t size;
        logic [4:0] target_gpr;
        logic [4:0] base_gpr;
        logic [4:0] index_gpr;
        logic [15:0] disp;
    } ilsu_req_t;

    // Data memory request
    typedef struct packed {
        logic valid;
        logic we;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } ilsu_mem_t;

endpackage

/* File: hw/ilsu_top.sv */
`timescale 1ns/1ps

// Operation
// R1: Displacement address is base plus sign-extended displacement; base field zero means zero.
// R2: Indexed address is base, or zero when base field zero, plus index register.
// R3: Algebraic halfword load fills bits above halfword with its most significant bit.
// R4: Word loads write the whole fetched word into the destination.
// R5: Load with update also writes the effective address into the base register.
// R6: Load with update and base field zero runs normally, address goes to register zero.
// R7: Load with update, base equal destination: register ends holding memory data.
// R8: Store with update, nonzero base, writes effective address to base after store.
// R9: Store with update and base field zero writes address into register zero.
// R10: Store with update, source equals base: old value stored, then address written.
// R11: Byte stores write source bits 24 to 31 to the addressed byte.
// R12: Halfword stores write source bits 16 to 31 to the addressed halfword.
// R13: Word stores write the complete source register to the addressed word.
// R14: Bit 0 is the most significant; memory byte order is big-endian.
// R15: Forms without update leave base and index registers unchanged.
module ilsu_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Issue side
    input wire logic i_req_valid,
    input wire ilsu_pkg::ilsu_req_t i_req,
    output logic o_req_ready,
    // Data memory side
    output ilsu_pkg::ilsu_mem_t o_mem,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    // Register file observation and completion pulse
    input wire logic [4:0] i_dbg_gpr,
    output logic [31:0] o_dbg_data,
    output logic o_done
);

    typedef enum logic [1:0] {
        ILSU_ST_IDLE = 2'b00,
        ILSU_ST_MEM = 2'b01,
        ILSU_ST_UPD = 2'b10
    } ilsu_state_t;

    ilsu_state_t state;
    ilsu_state_t next_state;
    ilsu_pkg::ilsu_req_t cur;
    logic [31:0] gpr [ilsu_pkg::ILSU_NREGS];
    logic [31:0] ea;
    logic [31:0] load_val;
    logic [31:0] load_q;
    logic take;
    logic ack_seen;
    logic wb_needed;
    logic ea_wr;
    logic data_wr;
    logic [31:0] ea_wr_sel;
    logic [31:0] data_wr_sel;
    logic [3:0] lane_hit_byte;
    logic [3:0] lane_hit_half;
    logic [7:0] rd_lane [4];

    // Handshake qualifiers
    assign take = (state == ILSU_ST_IDLE) && i_req_valid && o_req_ready;
    assign ack_seen = (state == ILSU_ST_MEM) && i_mem_ack;
    assign wb_needed = cur.update || !cur.is_store; // R5 R15
    assign ea_wr = ack_seen && cur.update; // R5 R6 R8 R9
    assign data_wr = (state == ILSU_ST_UPD) && !cur.is_store; // R3 R4 R7

    // Effective address and store data from the request offered on the issue port
    logic [31:0] base_val;
    logic [31:0] offset_val;
    logic [31:0] next_ea;
    logic [31:0] src_val;
    logic [1:0] lane;
    logic [31:0] next_wdata;
    logic [3:0] next_be;

    always_comb begin
        base_val = (i_req.base_gpr == ilsu_pkg::ILSU_ZERO_REG) ?
            ilsu_pkg::ILSU_GPR_RST : gpr[i_req.base_gpr]; // R1 R2
        offset_val = i_req.indexed ? gpr[i_req.index_gpr] :
            {{16{i_req.disp[15]}}, i_req.disp}; // R1 R2
        next_ea = base_val + offset_val; // R1 R2
    end

    // Per-lane store strobes; strobe bit 3 is lane 0
    for (genvar li = 0; li < 4; li++) begin : g_st_lane
        assign lane_hit_byte[3 - li] = (lane == 2'(li)); // R14
        assign lane_hit_half[3 - li] = (lane[1] == 1'(li / 2)); // R14
    end

    // Store lane placement; lane 0 is the lowest address and the MSB byte
    always_comb begin
        src_val = gpr[i_req.target_gpr];
        lane = next_ea[1:0];
        next_wdata = 32'h0000_0000;
        next_be = ilsu_pkg::ILSU_BE_NONE;
        unique case (i_req.size)
            ilsu_pkg::ILSU_SZ_BYTE: begin
                next_wdata = {4{src_val[7:0]}}; // R11
                next_be = lane_hit_byte; // R11 R14
            end
            ilsu_pkg::ILSU_SZ_HALF: begin
                next_wdata = {2{src_val[15:0]}}; // R12
                next_be = lane_hit_half; // R12 R14
            end
            default: begin
                next_wdata = src_val; // R13
                next_be = ilsu_pkg::ILSU_BE_ALL; // R13
            end
        endcase
    end

    // Read word split into lanes, lane 0 at the lowest address
    for (genvar ri = 0; ri < 4; ri++) begin : g_rd_lane
        assign rd_lane[ri] = i_mem_rdata[31 - 8 * ri -: 8]; // R14
    end

    // Load data extraction, big-endian lanes
    logic [15:0] half_sel;
    logic [7:0] byte_sel;
    always_comb begin
        half_sel = ea[1] ? {rd_lane[2], rd_lane[3]} : {rd_lane[0], rd_lane[1]}; // R14
        unique case (ea[1:0])
            2'b00: byte_sel = rd_lane[0];
            2'b01: byte_sel = rd_lane[1];
            2'b10: byte_sel = rd_lane[2];
            default: byte_sel = rd_lane[3];
        endcase
        unique case (cur.size)
            ilsu_pkg::ILSU_SZ_BYTE: load_val = {24'h00_0000, byte_sel};
            ilsu_pkg::ILSU_SZ_HALF: load_val = cur.algebraic ?
                {{16{half_sel[15]}}, half_sel} : {16'h0000, half_sel}; // R3
            default: load_val = i_mem_rdata; // R4
        endcase
    end

    // Next state; every load and every update form takes the write-back slot
    always_comb begin
        next_state = state;
        unique case (state)
            ILSU_ST_IDLE: begin
                if (take) begin
                    next_state = ILSU_ST_MEM;
                end
            end
            ILSU_ST_MEM: begin
                if (i_mem_ack) begin
                    next_state = wb_needed ? ILSU_ST_UPD : ILSU_ST_IDLE; // R15
                end
            end
            ILSU_ST_UPD: begin
                next_state = ILSU_ST_IDLE;
            end
            default: begin
                next_state = ILSU_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= ILSU_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Ready while idle and nothing is being taken
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_req_ready <= 1'b0;
        end else begin
            o_req_ready <= (next_state == ILSU_ST_IDLE);
        end
    end

    // Completion pulse
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_done <= 1'b0;
        end else begin
            o_done <= (ack_seen && !wb_needed) || (state == ILSU_ST_UPD);
        end
    end

    // Request capture
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cur <= '0;
        end else if (take) begin
            cur <= i_req;
        end
    end

    // Effective address capture
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ea <= ilsu_pkg::ILSU_GPR_RST;
        end else if (take) begin
            ea <= next_ea;
        end
    end

    // Next memory request; store data is captured before any register update
    ilsu_pkg::ilsu_mem_t next_mem;
    always_comb begin
        next_mem = '0;
        next_mem.valid = 1'b1;
        next_mem.we = i_req.is_store;
        next_mem.addr = next_ea;
        next_mem.be = i_req.is_store ? next_be : ilsu_pkg::ILSU_BE_ALL;
        next_mem.wdata = i_req.is_store ? next_wdata : 32'h0000_0000; // R10
    end

    // Memory request held until acknowledged
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mem <= '0;
        end else if (take) begin
            o_mem <= next_mem;
        end else if (ack_seen) begin
            o_mem <= '0;
        end
    end

    // One-hot register write selects
    always_comb begin
        ea_wr_sel = 32'h0000_0000;
        data_wr_sel = 32'h0000_0000;
        ea_wr_sel[cur.base_gpr] = ea_wr;
        data_wr_sel[cur.target_gpr] = data_wr;
    end

    // Register file; EA lands on the ack edge, load data one cycle later
    for (genvar gi = 0; gi < ilsu_pkg::ILSU_NREGS; gi++) begin : g_gpr
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                gpr[gi] <= ilsu_pkg::ILSU_GPR_RST;
            end else if (data_wr_sel[gi]) begin
                gpr[gi] <= load_q; // R7
            end else if (ea_wr_sel[gi]) begin
                gpr[gi] <= ea; // R5 R6 R8 R9 R10
            end
        end
    end

    // Loaded value held for the write-back slot
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            load_q <= ilsu_pkg::ILSU_GPR_RST;
        end else if (state == ILSU_ST_MEM && i_mem_ack) begin
            load_q <= load_val;
        end
    end

    // Debug read port
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_dbg_data <= ilsu_pkg::ILSU_GPR_RST;
        end else begin
            o_dbg_data <= gpr[i_dbg_gpr];
        end
    end

endmodule // ilsu_top

/* File: test/ilsu_top_assertions.sv */
`timescale 1ns/1ps
module ilsu_top_assertions (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Watched ports
    input wire logic i_req_valid,
    input wire ilsu_pkg::ilsu_req_t i_req,
    input wire logic o_req_ready,
    input wire ilsu_pkg::ilsu_mem_t o_mem,
    input wire logic i_mem_ack,
    input wire logic o_done
);
    ilsu_pkg::ilsu_req_t q;
    wire logic st = o_mem.valid && q.is_store;
    always_ff @(posedge i_clk) begin
        if (i_req_valid && o_req_ready) begin
            q <= i_req;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_issue_answer: assert property (i_req_valid && o_req_ready |=> o_mem.valid && !o_req_ready)
        else $error("no answer");
    a_mem_hold: assert property (o_mem.valid && !i_mem_ack |=> $stable(o_mem))
        else $error("request moved");
    a_ack_done: assert property (o_mem.valid && i_mem_ack |-> ##[1:3] o_done)
        else $error("no done");
    a_done_pulse: assert property (o_done |=> !o_done)
        else $error("done too long");
    a_we_kind: assert property (o_mem.valid |-> o_mem.we == q.is_store)
        else $error("bad we");
    a_disp_zero: assert property (o_mem.valid && !q.indexed && q.base_gpr == 5'h00
        |-> o_mem.addr == {{16{q.disp[15]}}, q.disp}) else $error("bad address");
    a_byte_lane: assert property (st && q.size == ilsu_pkg::ILSU_SZ_BYTE
        |-> o_mem.be == 4'h8 >> o_mem.addr[1:0]) else $error("bad byte lane");
    a_half_lane: assert property (st && q.size == ilsu_pkg::ILSU_SZ_HALF
        |-> o_mem.be == (o_mem.addr[1] ? 4'h3 : 4'hc)) else $error("bad half lane");
    a_word_lane: assert property (st && q.size == ilsu_pkg::ILSU_SZ_WORD
        |-> o_mem.be == 4'hf) else $error("bad word lane");
endmodule // ilsu_top_assertions

/* File: test/ilsu_mem_model.sv */
`timescale 1ns/1ps
module ilsu_mem_model (
    // Clock and delay
    input wire logic i_clk,
    input wire logic [3:0] i_delay,
    // Memory port
    input wire ilsu_pkg::ilsu_mem_t i_mem,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [3:0] cnt = 4'h0;
    initial o_ack = 1'b0;
    initial o_rdata = 32'h0;
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_mem.valid && !o_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt >= i_delay) begin
                cnt <= 4'h0;
                o_ack <= 1'b1;
                o_rdata <= {i_mem.addr[17:2], ~i_mem.addr[17:2]};
            end
        end
    end
endmodule // ilsu_mem_model

/* File: test/ilsu_top_test.sv */
`timescale 1ns/1ps
module ilsu_top_test;
    logic i_clk = 0, i_sys_rst = 1, i_req_valid = 0, i_mem_ack, o_req_ready, o_done;
    ilsu_pkg::ilsu_req_t i_req = '0;
    ilsu_pkg::ilsu_mem_t o_mem;
    logic [31:0] i_mem_rdata, o_dbg_data, seed = 32'hca5e1665, g[32] = '{default: 32'h0};
    logic [4:0] i_dbg_gpr = 5'h00;
    logic [3:0] dly = 4'h0;
    int bad_count = 0, compares = 0;
    ilsu_top DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_mem(o_mem), .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata), .i_dbg_gpr(i_dbg_gpr), .o_dbg_data(o_dbg_data), .o_done(o_done));
    ilsu_mem_model MEM (.i_clk(i_clk), .i_delay(dly), .i_mem(o_mem), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge i_clk) i_dbg_gpr <= a;
        @(posedge i_clk);
        @(negedge i_clk) chk(o_dbg_data, g[a]);
    endtask
    task automatic run(input ilsu_pkg::ilsu_req_t r, input logic [31:0] ea, s, be);
        int n;
        for (n = 0; n < 60 && o_req_ready !== 1'b1; n++) @(negedge i_clk);
        if (o_req_ready !== 1'b1) begin
            bad_count++;
            final_report();
        end
        @(posedge i_clk) i_req_valid <= 1'b1;
        i_req <= r;
        @(posedge i_clk) i_req_valid <= 1'b0;
        for (n = 0; n < 60 && o_done !== 1'b1; n++) begin
            @(negedge i_clk);
            if (o_mem.valid === 1'b1 && i_mem_ack === 1'b1) begin
                chk(o_mem.addr, ea);
                chk({31'h0, o_mem.we}, {31'h0, r.is_store});
                if (r.is_store) chk(o_mem.wdata, s);
                if (r.is_store) chk({28'h0, o_mem.be}, be);
            end
        end
        if (o_done !== 1'b1) begin
            bad_count++;
            final_report();
        end
    endtask
    task automatic op(input int k);
        ilsu_pkg::ilsu_req_t r;
        logic [31:0] ea, v, w, s, be;
        v = rnd();
        r = {v[4:0], rnd()};
        dly <= v[11:8];
        if (r.size == 2'b11 || k < 12) r.size = ilsu_pkg::ILSU_SZ_WORD;
        if (k < 20) r.is_store = 1'b0;
        if (k % 5 == 0) r.base_gpr = r.target_gpr;
        if (k % 7 == 0) r.base_gpr = 5'h00;
        ea = (r.base_gpr == 5'h00 ? 32'h0 : g[r.base_gpr]) +
            (r.indexed ? g[r.index_gpr] : {{16{r.disp[15]}}, r.disp});
        if (ea[0] || (ea[1] && r.size == ilsu_pkg::ILSU_SZ_WORD)) r.size = ilsu_pkg::ILSU_SZ_BYTE;
        if (r.size != ilsu_pkg::ILSU_SZ_HALF) r.algebraic = 1'b0;
        s = g[r.target_gpr];
        w = {ea[17:2], ~ea[17:2]} << {ea[1:0], 3'b000};
        be = 32'hf;
        v = {ea[17:2], ~ea[17:2]};
        if (r.size == ilsu_pkg::ILSU_SZ_HALF) begin
            s = {2{s[15:0]}};
            be = ea[1] ? 32'h3 : 32'hc;
            v = {{16{r.algebraic & w[31]}}, w[31:16]};
        end
        if (r.size == ilsu_pkg::ILSU_SZ_BYTE) begin
            s = {4{s[7:0]}};
            be = 32'h8 >> ea[1:0];
            v = {24'h0, w[31:24]};
        end
        run(r, ea, s, be);
        if (r.update) g[r.base_gpr] = ea;
        if (!r.is_store) g[r.target_gpr] = v;
        rd(r.base_gpr);
        rd(r.target_gpr);
        rd(r.index_gpr);
    endtask
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 400; k++) op(k);
        final_report();
    end
endmodule // ilsu_top_test
bind ilsu_top ilsu_top_assertions u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_mem(o_mem),
    .i_mem_ack(i_mem_ack), .o_done(o_done));
